// File: core/osc_core.sv
// Output servo, load-line positioning and PWM sync supervisor with APB registers

// What this block does
// - Every servo interval, step DAC one or two LSB, size set by range bit, toward target.
// - Servo is requested by bit 6 of the PWM mode register.
// - Servo only with bit set, rise done, no UV, no OC, load line zero.
// - Servo engages after turn-on time limit expires; zero limit means engage at once.
// - Load line lowers set point by percent at warning current, scaled, capped 15%.
// - Set points are no-load values; load line only ever lowers them.
// - Servo is kept off whenever load line is enabled.
// - Load line stays applied through every ramp, including turn-on rise.
// - Load line percent zero disables it, and zero is the reset value.
// - Load line is disabled when the feedback strap marks a slave phase.
// - Both channels follow the external sync clock when present.
// - Losing PLL lock while running sets status bit 4 and drives alert unless masked.
// - Writing one to status bit 4 clears the lock fault.
// - A channel stays off until PLL lock is indicated.
// - Starting a channel with unlocked ramp generator sets status bit 4.
// - Without external clock, PWM runs at the nonzero frequency setting.
// - External-only frequency code blocks start until an external clock is seen.
// - External-only with clock absent selects the lowest internal oscillator frequency.
// - Spurious lock alerts at start-up are suppressed by the mask bit.
module osc_core import osc_pkg::*; #(
  parameter int unsigned  SERVO_INTERVAL_CYC = SERVO_CYC,
  parameter int unsigned  MS_TICK_CYC        = MS_CYC,
  parameter logic [15:0]  VCO_MIN_CODE       = 16'h0001
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins from the analog side
  input  wire logic        pll_lock,
  input  wire logic [1:0]  ramp_lock,
  input  wire logic        ext_clk_present,
  input  wire logic        output_undervoltage_fault,
  input  wire logic        output_overcurrent_fault,
  input  wire logic        rise_done,
  input  wire logic        feedback_pin_slave,
  // Telemetry from on-chip ADC logic
  input  wire logic [15:0] adc_vout,
  input  wire logic [15:0] adc_iout,
  // Power stage and clock control
  output logic      [15:0] dac_code,
  output logic      [15:0] setpoint_code,
  output logic      [1:0]  chan_run,
  output logic             ext_clk_sel,
  output logic      [15:0] pll_freq_code,
  // Open-drain alert
  output logic             alert_o,
  output logic             alert_oe
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic        lk_s1, lk_s2, lk_prev;
    logic [1:0]  rl_s1, rl_s2;
    logic        ex_s1, ex_s2;
    logic        uv_s1, uv_s2;
    logic        oc_s1, oc_s2;
    logic        rd_s1, rd_s2;
    logic        fb_s1, fb_s2;
    logic [1:0]  strap_cnt;
    logic        slave;
    logic        servo_en;
    logic        vrange;
    logic [1:0]  run_req;
    logic [9:0]  ll_pct;
    logic [15:0] target;
    logic [15:0] iout_warn;
    logic [15:0] freq;
    logic [15:0] ton_max;
    logic        mask_lock;
    logic        lock_flt;
    logic [1:0]  run;
    osc_servo_t  sv;
    logic [19:0] int_cnt;
    logic [13:0] ms_cnt;
    logic [15:0] ms_elapsed;
    logic [15:0] trim;
    logic [15:0] sp;
    logic [15:0] dac;
    logic [15:0] fcode;
    logic        ack;
    logic [31:0] rdata;
  } osc_state_t;

  osc_state_t  s_r;
  osc_state_t  s_nxt;

  logic        bus_wr;
  logic        lock_set;
  logic        lock_clr;
  logic        ll_active;
  logic        servo_ok;
  logic        ton_expired;
  logic        sv_tick;
  logic        start_ok;
  logic [1:0]  start_edge;
  logic [9:0]  ll_eff;
  logic [25:0] ll_prod;
  logic [25:0] ll_frac_w;
  logic [9:0]  ll_frac;
  logic [25:0] red_w;
  logic [15:0] step;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == OFS_CTRL) || (a == OFS_LOADLINE) || (a == OFS_TARGET) ||
              (a == OFS_IWARN) || (a == OFS_FREQ) || (a == OFS_TONMAX) ||
              (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_DAC);
  endfunction

  // ****************************************
  // Shared terms
  // ****************************************
  assign bus_wr      = psel && penable && pwrite && s_r.ack && addr_ok(paddr);
  assign lock_clr    = bus_wr && (paddr == OFS_STATUS) && pwdata[ST_LOCKFLT];
  assign ll_active   = (s_r.ll_pct != 10'h000) && !s_r.slave;
  assign ton_expired = (s_r.ton_max == 16'h0000) || (s_r.ms_elapsed >= s_r.ton_max);
  assign servo_ok    = s_r.servo_en && s_r.rd_s2 && !s_r.uv_s2 && !s_r.oc_s2 &&
                       !ll_active && !s_r.slave && s_r.run[0];
  assign sv_tick     = (s_r.sv == SV_RUN) && (s_r.int_cnt == 20'(SERVO_INTERVAL_CYC - 1));
  // An external-only setting needs a clock on the sync pin before any start
  assign start_ok    = s_r.lk_s2 && ((s_r.freq != 16'h0000) || s_r.ex_s2);
  assign start_edge  = s_r.run_req & ~s_r.run & {2{start_ok}};
  assign lock_set    = (s_r.lk_prev && !s_r.lk_s2 && (|s_r.run)) ||
                       (|(start_edge & ~s_r.rl_s2));
  assign step        = s_r.vrange ? STEP_HI : STEP_LO;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    ll_eff = (s_r.ll_pct > LL_MAX) ? LL_MAX : s_r.ll_pct;
    ll_prod = 26'(ll_eff) * 26'(adc_iout);
    ll_frac_w = (s_r.iout_warn == 16'h0000) ? 26'(LL_MAX) : ll_prod / 26'(s_r.iout_warn);
    ll_frac = (ll_frac_w > 26'(LL_MAX)) ? LL_MAX : ll_frac_w[9:0];
    if (!ll_active) begin
      ll_frac = 10'h000;
    end
    red_w = (26'(s_r.target) * 26'(ll_frac)) / LL_SCALE;

    // Pin synchronisers
    s_nxt.lk_s1 = pll_lock;
    s_nxt.lk_s2 = s_r.lk_s1;
    s_nxt.lk_prev = s_r.lk_s2;
    s_nxt.rl_s1 = ramp_lock;
    s_nxt.rl_s2 = s_r.rl_s1;
    s_nxt.ex_s1 = ext_clk_present;
    s_nxt.ex_s2 = s_r.ex_s1;
    s_nxt.uv_s1 = output_undervoltage_fault;
    s_nxt.uv_s2 = s_r.uv_s1;
    s_nxt.oc_s1 = output_overcurrent_fault;
    s_nxt.oc_s2 = s_r.oc_s1;
    s_nxt.rd_s1 = rise_done;
    s_nxt.rd_s2 = s_r.rd_s1;
    s_nxt.fb_s1 = feedback_pin_slave;
    s_nxt.fb_s2 = s_r.fb_s1;

    // Strap is taken once, after the synchroniser has filled
    if (s_r.strap_cnt != 2'h3) begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
    end
    if (s_r.strap_cnt == STRAP_AT) begin
      s_nxt.slave = s_r.fb_s2;
    end

    // APB: one wait state, read data latched in the first access cycle
    s_nxt.ack = psel && penable && !s_r.ack;
    if (psel && penable && !s_r.ack) begin
      s_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        OFS_CTRL: begin
          s_nxt.rdata[CTL_RANGE] = s_r.vrange;
          s_nxt.rdata[CTL_SERVO] = s_r.servo_en;
          s_nxt.rdata[CTL_RUN_LSB +: 2] = s_r.run_req;
        end
        OFS_LOADLINE: s_nxt.rdata[9:0] = s_r.ll_pct;
        OFS_TARGET:   s_nxt.rdata[15:0] = s_r.target;
        OFS_IWARN:    s_nxt.rdata[15:0] = s_r.iout_warn;
        OFS_FREQ:     s_nxt.rdata[15:0] = s_r.freq;
        OFS_TONMAX:   s_nxt.rdata[15:0] = s_r.ton_max;
        OFS_STATUS: begin
          s_nxt.rdata[ST_PLL] = s_r.lk_s2;
          s_nxt.rdata[ST_EXT] = s_r.ex_s2;
          s_nxt.rdata[ST_SERVO] = (s_r.sv == SV_RUN);
          s_nxt.rdata[ST_SLAVE] = s_r.slave;
          s_nxt.rdata[ST_LOCKFLT] = s_r.lock_flt;
          s_nxt.rdata[ST_LL] = ll_active;
          s_nxt.rdata[ST_RUN_LSB +: 2] = s_r.run;
        end
        OFS_MASK:     s_nxt.rdata[ST_LOCKFLT] = s_r.mask_lock;
        OFS_DAC:      s_nxt.rdata = {s_r.sp, s_r.dac};
        default:      s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_wr) begin
      unique case (paddr)
        OFS_CTRL: begin
          s_nxt.vrange = pwdata[CTL_RANGE];
          s_nxt.servo_en = pwdata[CTL_SERVO];
          s_nxt.run_req = pwdata[CTL_RUN_LSB +: 2];
        end
        OFS_LOADLINE: s_nxt.ll_pct = pwdata[9:0];
        OFS_TARGET:   s_nxt.target = pwdata[15:0];
        OFS_IWARN:    s_nxt.iout_warn = pwdata[15:0];
        OFS_FREQ:     s_nxt.freq = pwdata[15:0];
        OFS_TONMAX:   s_nxt.ton_max = pwdata[15:0];
        OFS_MASK:     s_nxt.mask_lock = pwdata[ST_LOCKFLT];
        default:      s_nxt.mask_lock = s_r.mask_lock;
      endcase
    end

    // Lock fault: a new event beats a clear in the same cycle
    s_nxt.lock_flt = lock_set || (s_r.lock_flt && !lock_clr);

    // Channels run only once the PLL is locked; a lost lock later is flagged, not a stop
    for (int i = 0; i < 2; i++) begin
      if (!s_r.run_req[i]) begin
        s_nxt.run[i] = 1'b0;
      end else if (start_edge[i]) begin
        s_nxt.run[i] = 1'b1;
      end
    end

    // Clock source: external sync wins, else nonzero setting, else slowest VCO
    if (s_r.ex_s2) begin
      s_nxt.fcode = 16'h0000;
    end else if (s_r.freq != 16'h0000) begin
      s_nxt.fcode = s_r.freq;
    end else begin
      s_nxt.fcode = VCO_MIN_CODE;
    end

    // Turn-on timer in milliseconds, restarted whenever channel 0 is off
    if (!s_r.run[0]) begin
      s_nxt.ms_cnt = 14'h0000;
      s_nxt.ms_elapsed = 16'h0000;
    end else if (s_r.ms_cnt == 14'(MS_TICK_CYC - 1)) begin
      s_nxt.ms_cnt = 14'h0000;
      if (s_r.ms_elapsed != 16'hffff) begin
        s_nxt.ms_elapsed = s_r.ms_elapsed + 16'h0001;
      end
    end else begin
      s_nxt.ms_cnt = s_r.ms_cnt + 14'h0001;
    end

    // Servo loop
    unique case (s_r.sv)
      SV_OFF: begin
        s_nxt.int_cnt = 20'h00000;
        s_nxt.trim = 16'h0000;
        if (servo_ok && ton_expired) begin
          s_nxt.sv = SV_RUN;
        end
      end
      SV_RUN: begin
        if (!servo_ok) begin
          s_nxt.sv = SV_OFF;
        end else if (sv_tick) begin
          s_nxt.int_cnt = 20'h00000;
          if (adc_vout < s_r.target) begin
            s_nxt.trim = s_r.trim + step;
          end else if (adc_vout > s_r.target) begin
            s_nxt.trim = s_r.trim - step;
          end
        end else begin
          s_nxt.int_cnt = s_r.int_cnt + 20'h00001;
        end
      end
    endcase

    // Load line holds in every phase of operation, ramps included; it only subtracts
    s_nxt.sp = s_r.target - red_w[15:0];
    s_nxt.dac = s_r.sp + s_r.trim;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else if (pce) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata        = s_r.rdata;
  assign pready        = s_r.ack && pce;
  assign pslverr       = pready && !addr_ok(paddr);
  assign dac_code      = s_r.dac;
  assign setpoint_code = s_r.sp;
  assign chan_run      = s_r.run;
  assign ext_clk_sel   = s_r.ex_s2;
  assign pll_freq_code = s_r.fcode;
  assign alert_o       = 1'b0;
  // Masking hides start-up lock noise but also every real lock loss
  assign alert_oe      = s_r.lock_flt && !s_r.mask_lock;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_run_needs_lock: assert property ($rose(chan_run[0]) |-> $past(s_r.lk_s2))
    else $error("channel started without PLL lock");
  a_ext_only_wait: assert property ($rose(chan_run[1]) |-> $past(s_r.freq != 16'h0000 || s_r.ex_s2))
    else $error("external-only channel started without sync clock");
  a_lock_loss_flag: assert property (pce && lock_set && !s_r.mask_lock |=> alert_oe && s_r.lock_flt)
    else $error("lock loss did not raise alert");
  a_w1c_clear: assert property (pce && lock_clr && !lock_set |=> !s_r.lock_flt)
    else $error("write one did not clear lock fault");
  a_ll_blocks_servo: assert property (pce && ll_active |=> s_r.sv == SV_OFF)
    else $error("servo active with load line enabled");
  a_servo_drop: assert property (pce && s_r.sv == SV_RUN && !s_r.rd_s2 |=> s_r.sv == SV_OFF)
    else $error("servo kept running without rise done");
  a_ton_wait: assert property ($rose(s_r.sv == SV_RUN) |-> $past(ton_expired))
    else $error("servo engaged before turn-on limit");
  a_ll_lower_cap: assert property (pce |=> (s_r.sp <= $past(s_r.target)) &&
    (32'($past(s_r.target) - s_r.sp) * 32'd1000 <= 32'($past(s_r.target)) * 32'd150))
    else $error("load line raised or exceeded maximum");
  a_servo_step: assert property (pce && sv_tick && servo_ok && adc_vout < s_r.target |=>
    s_r.trim == $past(s_r.trim) + $past(step))
    else $error("servo step wrong size or direction");

endmodule

// File: core/osc_pkg.sv
// Shared constants, register map and types of the output servo and sync control block
package osc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned SERVO_MS     = 90;
  localparam int unsigned MS_CYC       = CLK_HZ / 1000;
  localparam int unsigned SERVO_CYC    = SERVO_MS * MS_CYC;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_LOADLINE  = 8'h04;
  localparam logic [7:0] OFS_TARGET    = 8'h08;
  localparam logic [7:0] OFS_IWARN     = 8'h0c;
  localparam logic [7:0] OFS_FREQ      = 8'h10;
  localparam logic [7:0] OFS_TONMAX    = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_MASK      = 8'h1c;
  localparam logic [7:0] OFS_DAC       = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTL_RANGE    = 0;
  localparam int unsigned CTL_SERVO    = 6;
  localparam int unsigned CTL_RUN_LSB  = 8;
  localparam int unsigned ST_PLL       = 0;
  localparam int unsigned ST_EXT       = 1;
  localparam int unsigned ST_SERVO     = 2;
  localparam int unsigned ST_SLAVE     = 3;
  localparam int unsigned ST_LOCKFLT   = 4;
  localparam int unsigned ST_LL        = 5;
  localparam int unsigned ST_RUN_LSB   = 8;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [15:0] STEP_LO      = 16'h0001;
  localparam logic [15:0] STEP_HI      = 16'h0002;
  localparam logic [9:0]  LL_MAX       = 10'h096;
  localparam logic [25:0] LL_SCALE     = 26'h00003e8;
  localparam logic [1:0]  STRAP_AT     = 2'h2;

  typedef enum logic {SV_OFF, SV_RUN} osc_servo_t;

endpackage

// File: verification/osc_power_stage.sv
// Power stage model: the output reading follows the DAC code plus an offset
module osc_power_stage (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench control
  input  wire logic        slow,
  input  wire logic [15:0] vout_ofs,
  // Loop signals
  input  wire logic [15:0] dac_code,
  output logic      [15:0] adc_vout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_r;
  // A slow stage settles only every fourth cycle, so the reading lags the code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      adc_vout <= 16'h0000;
    end else begin
      div_r <= div_r + 2'h1;
      if (!slow || div_r == 2'h0) begin
        adc_vout <= dac_code + vout_ofs;
      end
    end
  end
endmodule

// File: verification/test_output_servo_avp_sync_control.sv
// Self-checking bench of the servo, load-line and sync control block
module test_output_servo_avp_sync_control import osc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IV = 20;
  localparam logic [15:0] VM = 16'h0011;
  logic pclk, presetn, pce, psel, penable, pwrite, pll_lock, ext_clk_present, uv, oc, rise_done, slave, slow;
  logic pready, pslverr, err, alert_o, alert_oe, ext_clk_sel;
  logic [1:0] ramp_lock, chan_run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] seed = 32'hb420;
  logic [15:0] adc_vout, adc_iout, dac_code, setpoint_code, pll_freq_code, vout_ofs;
  logic [15:0] tbl [4] = '{16'h0000, 16'h0032, 16'h0064, 16'h00c8};
  int miscompares, samples_checked, pct;

  osc_core #(.SERVO_INTERVAL_CYC(IV), .MS_TICK_CYC(4), .VCO_MIN_CODE(VM)) u_osc_core (
    .pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pll_lock, .ramp_lock, .ext_clk_present, .output_undervoltage_fault(uv), .output_overcurrent_fault(oc),
    .rise_done, .feedback_pin_slave(slave), .adc_vout, .adc_iout, .dac_code, .setpoint_code, .chan_run,
    .ext_clk_sel, .pll_freq_code, .alert_o, .alert_oe);
  osc_power_stage u_osc_power_stage (.pclk, .presetn, .slow, .vout_ofs, .dac_code, .adc_vout);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ****************************************
  // Bench tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) miscompares++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  task do_reset(input logic s);
    presetn <= 1'b0;
    slave <= s;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle;
  endtask
  // Check the start code, then wait bounded until the goal code is reached
  task wait_dac(input logic [15:0] from, input logic [15:0] e, input int lim);
    int n;
    n = 0;
    chk(dac_code, from);
    while (dac_code !== e && n < lim) begin
      n++;
      @(posedge pclk);
    end
    chk(dac_code, e);
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] ll_exp(int t, int p, int i, int w);
    int f;
    f = (p > 150 ? 150 : p) * i / w;
    if (f > 150) f = 150;
    return 16'(t - t * f / 1000);
  endfunction
  task brk(input int c, input logic on);
    case (c)
      0: uv <= on;
      1: oc <= on;
      2: rise_done <= !on;
      3: apb(1'b1, OFS_CTRL, on ? 32'h300 : 32'h340);
      default: apb(1'b1, OFS_LOADLINE, {31'h0, on});
    endcase
  endtask
  task wrap_up;
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    wrap_up;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {pce, psel, penable, pwrite, pll_lock, ext_clk_present, uv, oc, rise_done, slave, slow} = 11'h400;
    {paddr, pwdata, ramp_lock, vout_ofs, adc_iout} = '0;
    presetn = 1'b0;
    do_reset(1'b0);
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, 32'h0);
      chk(err, i == 9);
    end
    apb(1'b1, OFS_FREQ, 32'h190);
    apb(1'b1, OFS_CTRL, 32'h300);
    settle;
    chk(chan_run, 2'h0);
    chk(pll_freq_code, 16'h0190);
    pll_lock <= 1'b1;
    ramp_lock <= 2'h1;
    settle;
    chk(chan_run, 2'h3);
    apb(1'b1, OFS_STATUS, 32'hffef);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[4], 1'b1);
    chk(alert_oe, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h10);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[4], 1'b0);
    pll_lock <= 1'b0;
    settle;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[4], 1'b1);
    chk({alert_o, alert_oe}, 2'h1);
    apb(1'b1, OFS_MASK, 32'h10);
    settle;
    chk(alert_oe, 1'b0);
    apb(1'b1, OFS_STATUS, 32'h10);
    apb(1'b1, OFS_MASK, 32'h0);
    pll_lock <= 1'b1;
    ramp_lock <= 2'h3;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_FREQ, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h300);
    settle;
    chk(pll_freq_code, VM);
    chk(chan_run, 2'h0);
    ext_clk_present <= 1'b1;
    settle;
    chk(chan_run, 2'h3);
    chk({ext_clk_sel, pll_freq_code}, 17'h10000);
    ext_clk_present <= 1'b0;
    settle;
    chk(pll_freq_code, VM);
    apb(1'b1, OFS_FREQ, 32'h190);
    // ****************************************
    // Load line, applied while the rise ramp is still running
    // ****************************************
    apb(1'b1, OFS_TARGET, 32'h3e8);
    apb(1'b1, OFS_IWARN, 32'h64);
    apb(1'b1, OFS_CTRL, 32'h340);
    for (int k = 0; k < 8; k++) begin
      pct = (k == 0) ? 198 : int'(xs() % 100) * 2;
      adc_iout <= (k == 0) ? 16'h00c8 : tbl[xs() % 4];
      apb(1'b1, OFS_LOADLINE, 32'(pct));
      settle;
      chk(setpoint_code, ll_exp(1000, pct, int'(adc_iout), 100));
      chk(dac_code, setpoint_code);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({q[5], q[2]}, {pct != 0, 1'b0});
    end
    // ****************************************
    // Servo: turn-on limit, step, direction, and the UV, OC, rise-done, servo-bit and load-line conditions
    // ****************************************
    apb(1'b1, OFS_LOADLINE, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_TONMAX, 32'h28);
    adc_iout <= 16'h0;
    vout_ofs <= 16'h0003;
    rise_done <= 1'b1;
    settle;
    apb(1'b1, OFS_CTRL, 32'h340);
    repeat (60) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[2], 1'b0);
    wait_dac(16'h03e8, 16'h03e7, 400);
    wait_dac(16'h03e7, 16'h03e5, 200);
    repeat (3 * IV) @(posedge pclk);
    chk(dac_code, 16'h03e5);
    for (int c = 0; c < 5; c++) begin
      brk(c, 1'b1);
      settle;
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({q[2], dac_code}, 17'h003e8);
      brk(c, 1'b0);
      wait_dac(16'h03e8, 16'h03e5, 200);
    end
    do_reset(1'b1);
    apb(1'b1, OFS_TARGET, 32'h3e8);
    apb(1'b1, OFS_IWARN, 32'h64);
    apb(1'b1, OFS_LOADLINE, 32'h64);
    adc_iout <= 16'h0064;
    settle;
    chk(setpoint_code, 16'h03e8);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({q[5], q[3]}, 2'h1);
    do_reset(1'b0);
    slow <= 1'b1;
    vout_ofs <= 16'hfffc;
    apb(1'b1, OFS_FREQ, 32'h190);
    apb(1'b1, OFS_TARGET, 32'h3e8);
    settle;
    apb(1'b1, OFS_CTRL, 32'h341);
    wait_dac(16'h03e8, 16'h03ea, 60);
    // Clock enable low must freeze the servo between steps
    pce <= 1'b0;
    repeat (3 * IV) @(posedge pclk);
    chk(dac_code, 16'h03ea);
    pce <= 1'b1;
    wait_dac(16'h03ea, 16'h03ec, 200);
    repeat (3 * IV) @(posedge pclk);
    chk(dac_code, 16'h03ec);
    wrap_up;
  end
endmodule
